// >>> rtl/prog_pin_pkg.sv
// Shared constants and types for the programming-pin and clock/reset pin logic
package prog_pin_pkg;

    // Array dimensions
    localparam int IO_COUNT     = 64;
    localparam int GLB_COUNT    = 32;
    localparam int DED_COUNT    = 8;
    localparam int SHARED_COUNT = 4;
    localparam int HI_DED_COUNT = DED_COUNT - SHARED_COUNT;
    localparam int WORD_BITS    = 8;
    localparam int BUF_DEPTH    = 2;

    // Serial programming word
    typedef logic [WORD_BITS-1:0] word_t;

    // Values after reset
    localparam word_t                    WORD_RESET   = 8'h00;
    localparam logic [SHARED_COUNT-1:0]  SHARED_IDLE  = 4'h0;
    localparam logic [DED_COUNT-1:0]     DED_RESET    = 8'h00;
    localparam logic [IO_COUNT-1:0]      IO_RESET     = 64'h0;
    localparam logic                     PIN_HIGH     = 1'b1;
    localparam logic                     PIN_LOW      = 1'b0;

    // Internal programming sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_EXEC  = 2'b10
    } prog_state_e;

endpackage

// >>> rtl/word_if.sv
// Valid/ready word channel between the pin logic and its word buffer
`timescale 1ns/1ns
interface word_if;
    import prog_pin_pkg::*;

    logic  valid;
    logic  ready;
    word_t data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/bit_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ns
module bit_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Destination domain
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Level in and synchronised level out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    // Stage one feeds only stage two
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            stage1 <= INIT;
            dout   <= INIT;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// >>> rtl/word_buffer.sv
// Two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ns
module word_buffer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Filling and draining sides
    word_if.snk       fill,
    word_if.src       drain
);
    import prog_pin_pkg::*;

    word_t      mem [BUF_DEPTH];
    word_t      next_mem [BUF_DEPTH];
    logic       wr_ptr;
    logic       rd_ptr;
    logic [1:0] count;
    logic       next_wr_ptr;
    logic       next_rd_ptr;
    logic [1:0] next_count;
    logic       push;
    logic       pop;

    // Full refuses the filler, which holds its word until taken
    assign fill.ready  = (count != 2'(BUF_DEPTH));
    assign drain.valid = (count != 2'h0);
    assign drain.data  = mem[rd_ptr];
    assign push        = fill.valid && fill.ready;
    assign pop         = drain.valid && drain.ready;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = fill.data;
            next_wr_ptr      = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mem    <= '{default: WORD_RESET};
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            mem    <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule

// >>> rtl/prog_pin_mode_mux.sv
// Dual-function programming pins, global reset pin and dedicated clock routing
//
// Notes on behaviour
// - Holding prog_enable_n low puts the device in programming mode and high keeps it normal.
// - In programming mode the serial in, serial out, shift clock and mode pins take that role.
// - The serial_prog_in pin is dedicated input 0 in normal mode and programming data otherwise.
// - In programming mode serial_prog_in also steers the programming sequencer with the mode pin.
// - The mode pin is dedicated input 1 in normal mode and sequencer control otherwise.
// - The serial-out pin is dedicated input 2 in normal mode and drives shift data otherwise.
// - The shift-clock pin is dedicated input 3 in normal mode and clocks the shift register else.
// - A low on the global reset pin resets every logic block and I/O cell register.
// - Clock input 0 is wired straight to one clock of every logic block.
// - Clock input 1 is selectable per configuration as a clock of any logic block.
// - Clock input 2 is selectable as a clock of any logic block, any I/O cell, or both.
// - Clock input 3 is selectable only as a clock of any I/O cell.
// - Sixty-four bidirectional pins serve the array, plus dedicated inputs four to seven.
`timescale 1ns/1ns
module prog_pin_mode_mux (
    // System clock and reset
    input  wire logic                               clk,
    input  wire logic                               rst_b,
    // Programming port pins
    input  wire logic                               prog_enable_n,
    input  wire logic                               serial_prog_in,
    input  wire logic                               mode_ctrl_in,
    input  wire logic                               shift_clk,
    input  wire logic                               serial_prog_out_in,
    output logic                                    serial_prog_out,
    output logic                                    serial_prog_out_oe,
    // Dedicated inputs four to seven and inputs to the array
    input  wire logic [prog_pin_pkg::HI_DED_COUNT-1:0] ded_in_pins,
    output logic      [prog_pin_pkg::DED_COUNT-1:0]    dedicated_in,
    // Global reset pin and distributed resets
    input  wire logic                               reset_n,
    output logic                                    glb_reset_n,
    output logic                                    io_reset_n,
    // Dedicated clocks and routing selections
    input  wire logic                               clock_in_0,
    input  wire logic                               clock_in_1,
    input  wire logic                               clock_in_2,
    input  wire logic                               clock_in_3,
    input  wire logic [prog_pin_pkg::GLB_COUNT-1:0] glb_clk_sel,
    input  wire logic [prog_pin_pkg::IO_COUNT-1:0]  io_clk_sel,
    output logic      [prog_pin_pkg::GLB_COUNT-1:0] glb_clk0,
    output logic      [prog_pin_pkg::GLB_COUNT-1:0] glb_clk1,
    output logic      [prog_pin_pkg::IO_COUNT-1:0]  io_clk,
    // General-purpose bidirectional pins
    input  wire logic [prog_pin_pkg::IO_COUNT-1:0]  io_pin_in,
    output logic      [prog_pin_pkg::IO_COUNT-1:0]  io_pin_out,
    output logic      [prog_pin_pkg::IO_COUNT-1:0]  io_pin_oe,
    // Array side of the bidirectional pins
    output logic      [prog_pin_pkg::IO_COUNT-1:0]  array_in,
    input  wire logic [prog_pin_pkg::IO_COUNT-1:0]  array_out,
    input  wire logic [prog_pin_pkg::IO_COUNT-1:0]  array_oe,
    // Received programming words
    output prog_pin_pkg::word_t                     prog_word,
    output logic                                    prog_word_valid,
    input  wire logic                               prog_word_ready
);
    import prog_pin_pkg::*;

    // ---------------- Link domain, clocked by the shift-clock pin ----------------
    logic        link_prog_n;
    logic        link_ack;
    prog_state_e state;
    prog_state_e next_state;
    word_t       shreg;
    word_t       next_shreg;
    word_t       held_word;
    word_t       next_held_word;
    logic        out_bit;
    logic        next_out_bit;
    logic        req_toggle;
    logic        next_req_toggle;
    logic        link_pending;
    logic        ack_toggle;

    bit_sync #(.W(1), .INIT(PIN_HIGH)) u_link_prog_sync (
        .clk   (shift_clk),
        .rst_b (PIN_HIGH),
        .din   (prog_enable_n),
        .dout  (link_prog_n)
    );

    bit_sync #(.W(1), .INIT(PIN_LOW)) u_link_ack_sync (
        .clk   (shift_clk),
        .rst_b (PIN_HIGH),
        .din   (ack_toggle),
        .dout  (link_ack)
    );

    // A word handed over but not yet acknowledged by the system domain
    assign link_pending = req_toggle ^ link_ack;

    always_comb begin
        next_state      = state;
        next_shreg      = shreg;
        next_held_word  = held_word;
        next_out_bit    = out_bit;
        next_req_toggle = req_toggle;
        if (link_prog_n) begin
            // Leaving programming mode drops any pending hand-over cleanly
            next_state      = ST_IDLE;
            next_shreg      = WORD_RESET;
            next_out_bit    = PIN_LOW;
            next_req_toggle = link_ack;
        end else if (mode_ctrl_in) begin
            // Mode high: serial_prog_in picks advance or hold
            if (serial_prog_in) begin
                unique case (state)
                    ST_IDLE:  next_state = ST_SHIFT;
                    ST_SHIFT: next_state = ST_EXEC;
                    ST_EXEC:  next_state = ST_IDLE;
                    default:  next_state = ST_IDLE;
                endcase
            end
        end else begin
            unique case (state)
                ST_IDLE: begin
                    next_state = ST_IDLE;
                end
                ST_SHIFT: begin
                    next_shreg   = {serial_prog_in, shreg[WORD_BITS-1:1]};
                    next_out_bit = shreg[0];
                end
                ST_EXEC: begin
                    // Stalls here while the previous word is still in flight
                    if (!link_pending) begin
                        next_held_word  = shreg;
                        next_req_toggle = ~req_toggle;
                    end
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge shift_clk) begin
        state      <= next_state;
        shreg      <= next_shreg;
        held_word  <= next_held_word;
        out_bit    <= next_out_bit;
        req_toggle <= next_req_toggle;
    end

    // ---------------- System domain ----------------
    logic                    prog_n_sync;
    logic                    prog_mode;
    logic                    reset_pin_sync;
    logic                    req_sync;
    logic                    next_ack_toggle;
    logic [SHARED_COUNT-1:0] shared_sync;
    logic [HI_DED_COUNT-1:0] hi_ded_sync;
    logic [IO_COUNT-1:0]     io_sync;
    logic [DED_COUNT-1:0]    next_dedicated_in;
    logic                    next_glb_reset_n;
    word_if                  fill_ch ();
    word_if                  drain_ch ();

    bit_sync #(.W(1), .INIT(PIN_HIGH)) u_prog_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (prog_enable_n),
        .dout  (prog_n_sync)
    );

    bit_sync #(.W(1), .INIT(PIN_LOW)) u_reset_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (reset_n),
        .dout  (reset_pin_sync)
    );

    bit_sync #(.W(1), .INIT(PIN_LOW)) u_req_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (req_toggle),
        .dout  (req_sync)
    );

    bit_sync #(.W(SHARED_COUNT), .INIT(SHARED_IDLE)) u_shared_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({shift_clk, serial_prog_out_in, mode_ctrl_in, serial_prog_in}),
        .dout  (shared_sync)
    );

    bit_sync #(.W(HI_DED_COUNT), .INIT(SHARED_IDLE)) u_hi_ded_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (ded_in_pins),
        .dout  (hi_ded_sync)
    );

    bit_sync #(.W(IO_COUNT), .INIT(IO_RESET)) u_io_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (io_pin_in),
        .dout  (io_sync)
    );

    assign prog_mode = !prog_n_sync;

    // Serial out drives only while programming; it floats again on exit
    assign serial_prog_out    = out_bit;
    assign serial_prog_out_oe = prog_mode;

    // Held word is stable while the request toggle is pending, so it is safe to sample
    assign fill_ch.valid   = req_sync ^ ack_toggle;
    assign fill_ch.data    = held_word;
    assign drain_ch.ready  = prog_word_ready;
    assign prog_word       = drain_ch.data;
    assign prog_word_valid = drain_ch.valid;

    word_buffer u_word_buffer (
        .clk   (clk),
        .rst_b (rst_b),
        .fill  (fill_ch),
        .drain (drain_ch)
    );

    always_comb begin
        next_ack_toggle = ack_toggle;
        if (fill_ch.valid && fill_ch.ready) begin
            next_ack_toggle = req_sync;
        end
        // Shared pins are masked from the array while they serve programming
        next_dedicated_in = {hi_ded_sync, prog_mode ? SHARED_IDLE : shared_sync};
        next_glb_reset_n  = reset_pin_sync;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_toggle   <= PIN_LOW;
            dedicated_in <= DED_RESET;
            glb_reset_n  <= PIN_LOW;
            io_reset_n   <= PIN_LOW;
            array_in     <= IO_RESET;
            io_pin_out   <= IO_RESET;
            io_pin_oe    <= IO_RESET;
        end else begin
            ack_toggle   <= next_ack_toggle;
            dedicated_in <= next_dedicated_in;
            glb_reset_n  <= next_glb_reset_n;
            io_reset_n   <= next_glb_reset_n;
            array_in     <= io_sync;
            io_pin_out   <= array_out;
            io_pin_oe    <= array_oe;
        end
    end

    // ---------------- Clock routing; clocks are never registered ----------------
    genvar g;
    generate
        for (g = 0; g < IO_COUNT; g++) begin : gen_io_clk
            assign io_clk[g] = io_clk_sel[g] ? clock_in_3 : clock_in_2;
            if (g < GLB_COUNT) begin : gen_glb_clk
                assign glb_clk0[g] = clock_in_0;
                assign glb_clk1[g] = glb_clk_sel[g] ? clock_in_2 : clock_in_1;
            end
        end
    endgenerate

    // ---------------- Checks ----------------
    chk_sdo_drive: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!prog_enable_n) [*3] |-> serial_prog_out_oe)
        else $error("serial out not driven in programming mode");

    chk_sdo_release: assert property (
        @(posedge clk) disable iff (!rst_b)
        prog_enable_n [*3] |-> !serial_prog_out_oe)
        else $error("serial out still driven in normal mode");

    chk_shared_mask: assert property (
        @(posedge clk) disable iff (!rst_b)
        prog_mode |=> dedicated_in[SHARED_COUNT-1:0] == SHARED_IDLE)
        else $error("shared pins leak into array during programming");

    chk_shared_pass: assert property (
        @(posedge clk) disable iff (!rst_b)
        !prog_mode ##1 !prog_mode |-> dedicated_in == {$past(hi_ded_sync), $past(shared_sync)})
        else $error("dedicated inputs not passed in normal mode");

    chk_global_reset: assert property (
        @(posedge clk) disable iff (!rst_b)
        (!reset_n) [*3] |=> !glb_reset_n && !io_reset_n)
        else $error("global reset pin not applied");

    chk_io_path: assert property (
        @(posedge clk) disable iff (!rst_b)
        ##3 array_in == $past(io_pin_in, 3))
        else $error("pin input not delivered to array");

    chk_glb_clock_sel: assert property (
        @(posedge clk) disable iff (!rst_b)
        glb_clk1[0] == (glb_clk_sel[0] ? clock_in_2 : clock_in_1) && glb_clk0[0] == clock_in_0)
        else $error("logic block clock routing wrong");

    chk_io_clock_sel: assert property (
        @(posedge clk) disable iff (!rst_b)
        io_clk[IO_COUNT-1] == (io_clk_sel[IO_COUNT-1] ? clock_in_3 : clock_in_2))
        else $error("I/O cell clock routing wrong");

    chk_shift_out: assert property (
        @(posedge shift_clk) disable iff (link_prog_n)
        state == ST_SHIFT && !mode_ctrl_in |=> serial_prog_out == $past(shreg[0]))
        else $error("shift register not presented on serial out");

    chk_seq_advance: assert property (
        @(posedge shift_clk) disable iff (link_prog_n)
        state == ST_SHIFT && mode_ctrl_in && serial_prog_in |=> state == ST_EXEC)
        else $error("sequencer did not advance on control");

    chk_word_ack: assert property (
        @(posedge clk) disable iff (!rst_b)
        fill_ch.valid && fill_ch.ready |=> ack_toggle == $past(req_sync))
        else $error("handed word not acknowledged");
endmodule

// >>> dv/prog_ctrl_model.sv
// Behavioural programming controller driving the device's serial port
`timescale 1ns/1ns
module prog_ctrl_model (
    // Pins driven toward the device
    output logic      prog_enable_n,
    output logic      serial_prog_in,
    output logic      mode_ctrl_in,
    output logic      shift_clk,
    // Serial data returned by the device
    input  wire logic serial_prog_out
);
    import prog_pin_pkg::*;

    logic smp;

    initial begin
        prog_enable_n  = 1'b1;
        serial_prog_in = 1'b0;
        mode_ctrl_in   = 1'b0;
        shift_clk      = 1'b0;
        smp            = 1'b0;
    end

    // Link clock only runs inside frames; pins change while it is low
    task automatic tick(input logic m, input logic d);
        mode_ctrl_in   = m;
        serial_prog_in = d;
        #13 shift_clk = 1'b1;
        #20 smp = serial_prog_out;
        #20 shift_clk = 1'b0;
        #27;
    endtask

    // Normal mode: the shared pins are plain dedicated inputs
    task automatic set_pins(input logic d, input logic m, input logic c);
        serial_prog_in = d;
        mode_ctrl_in   = m;
        shift_clk      = c;
    endtask

    // Low enable selects programming; idle ticks let the link side leave reset
    task automatic enter();
        shift_clk     = 1'b0;
        prog_enable_n = 1'b0;
        #300;
        repeat (3) tick(1'b0, 1'b0);
    endtask

    task automatic leave();
        prog_enable_n = 1'b1;
        #300;
    endtask

    // One full word, LSB first; back holds what the device shifted out
    task automatic send(input word_t w, output word_t back);
        tick(1'b1, 1'b1);
        for (int i = 0; i < WORD_BITS; i++) begin
            tick(1'b0, w[i]);
            back[i] = smp;
        end
        tick(1'b1, 1'b1);
        tick(1'b0, 1'b0);
        tick(1'b1, 1'b1);
    endtask
endmodule

// >>> dv/prog_pin_mode_mux_tb.sv
// Self-checking bench for the programming pin mux
`timescale 1ns/1ns
module prog_pin_mode_mux_tb;
    import prog_pin_pkg::*;

    logic clk, rst_b, sdo_drv, serial_prog_out, serial_prog_out_oe, serial_prog_out_in;
    logic reset_n, glb_reset_n, io_reset_n, prog_word_valid, prog_word_ready;
    logic clock_in_0, clock_in_1, clock_in_2, clock_in_3;
    logic [HI_DED_COUNT-1:0] ded_in_pins;
    logic [DED_COUNT-1:0]    dedicated_in;
    logic [GLB_COUNT-1:0]    glb_clk_sel, glb_clk0, glb_clk1;
    logic [IO_COUNT-1:0]     io_clk_sel, io_clk, io_pin_in, io_pin_out, io_pin_oe;
    logic [IO_COUNT-1:0]     array_in, array_out, array_oe;
    word_t                   prog_word, back;
    wire logic               prog_enable_n, serial_prog_in, mode_ctrl_in, shift_clk;
    int                      error_cnt, comparisons, cyc;

    // Serial-out pin level: the device wins while enabled, else the board drives it
    assign serial_prog_out_in = serial_prog_out_oe ? serial_prog_out : sdo_drv;

    prog_pin_mode_mux dut (.clk, .rst_b, .prog_enable_n, .serial_prog_in, .mode_ctrl_in,
        .shift_clk, .serial_prog_out_in, .serial_prog_out, .serial_prog_out_oe,
        .ded_in_pins, .dedicated_in, .reset_n, .glb_reset_n, .io_reset_n, .clock_in_0,
        .clock_in_1, .clock_in_2, .clock_in_3, .glb_clk_sel, .io_clk_sel, .glb_clk0,
        .glb_clk1, .io_clk, .io_pin_in, .io_pin_out, .io_pin_oe, .array_in, .array_out,
        .array_oe, .prog_word, .prog_word_valid, .prog_word_ready);

    // The controller reads the pin level, so a released pin shows the board's value
    prog_ctrl_model model (.prog_enable_n, .serial_prog_in, .mode_ctrl_in, .shift_clk,
        .serial_prog_out (serial_prog_out_in));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end

    // Waits for a buffered word and takes it with a one-cycle ready; starting on a
    // falling edge keeps one clock edge between two pops' ready pulses
    task automatic pop(input word_t exp);
        int n;
        n = 0;
        cycles(1);
        while (prog_word_valid !== 1'b1 && n < 60) begin
            cycles(1);
            n++;
        end
        chk("word_valid", 64'h1, {63'h0, prog_word_valid});
        chk("word", {56'h0, exp}, {56'h0, prog_word});
        prog_word_ready = 1'b1;
        cycles(1);
        prog_word_ready = 1'b0;
    endtask

    task automatic t_normal();
        model.set_pins(1'b1, 1'b0, 1'b1);
        sdo_drv     = 1'b1;
        ded_in_pins = 4'ha;
        io_pin_in   = 64'h0123_4567_89ab_cdef;
        array_out   = 64'hfedc_ba98_7654_3210;
        array_oe    = 64'h00ff_00ff_f0f0_0f0f;
        cycles(1);
        chk("io_pin_out", 64'hfedc_ba98_7654_3210, io_pin_out);
        chk("io_pin_oe", 64'h00ff_00ff_f0f0_0f0f, io_pin_oe);
        cycles(3);
        chk("array_in", 64'h0123_4567_89ab_cdef, array_in);
        chk("dedicated_in", 64'had, {56'h0, dedicated_in});
        chk("sdo_oe", 64'h0, {63'h0, serial_prog_out_oe});
        model.set_pins(1'b0, 1'b1, 1'b0);
        sdo_drv     = 1'b0;
        ded_in_pins = 4'h5;
        cycles(4);
        chk("dedicated_in", 64'h52, {56'h0, dedicated_in});
        $display("test normal done");
    endtask

    task automatic t_program();
        model.enter();
        cycles(4);
        chk("sdo_oe", 64'h1, {63'h0, serial_prog_out_oe});
        chk("dedicated_in", 64'h50, {56'h0, dedicated_in});
        model.send(8'ha5, back);
        pop(8'ha5);
        // Receiver stalls while two words arrive
        model.send(8'h3c, back);
        chk("shift_out", 64'ha5, {56'h0, back});
        model.send(8'hc3, back);
        chk("shift_out", 64'h3c, {56'h0, back});
        cycles(5);
        chk("valid_held", 64'h1, {63'h0, prog_word_valid});
        pop(8'h3c);
        pop(8'hc3);
        chk("drained", 64'h0, {63'h0, prog_word_valid});
        // Leave first and keep the shift pin low, so no stray link edge hits the sequencer
        model.leave();
        model.set_pins(1'b1, 1'b1, 1'b0);
        sdo_drv = 1'b1;
        cycles(4);
        chk("sdo_oe", 64'h0, {63'h0, serial_prog_out_oe});
        chk("dedicated_in", 64'h57, {56'h0, dedicated_in});
        $display("test program done");
    endtask

    task automatic t_reset();
        reset_n = 1'b0;
        cycles(2);
        chk("glb_reset_n", 64'h1, {63'h0, glb_reset_n});
        cycles(2);
        chk("glb_reset_n", 64'h0, {63'h0, glb_reset_n});
        chk("io_reset_n", 64'h0, {63'h0, io_reset_n});
        reset_n = 1'b1;
        cycles(4);
        chk("io_reset_n", 64'h1, {63'h0, io_reset_n});
        $display("test reset done");
    endtask

    task automatic t_clocks();
        logic [3:0] c;
        glb_clk_sel = 32'hf0f0_a5a5;
        io_clk_sel  = 64'h0ff0_1234_cafe_5a5a;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            {clock_in_3, clock_in_2, clock_in_1, clock_in_0} = c;
            #1;
            chk("glb_clk0", {32'h0, {32{c[0]}}}, {32'h0, glb_clk0});
            chk("glb_clk1", {32'h0, (glb_clk_sel & {32{c[2]}}) | (~glb_clk_sel & {32{c[1]}})},
                {32'h0, glb_clk1});
            chk("io_clk", (io_clk_sel & {64{c[3]}}) | (~io_clk_sel & {64{c[2]}}), io_clk);
        end
        $display("test clocks done");
    endtask

    initial begin
        rst_b           = 1'b0;
        sdo_drv         = 1'b0;
        reset_n         = 1'b1;
        prog_word_ready = 1'b0;
        {clock_in_3, clock_in_2, clock_in_1, clock_in_0} = 4'h0;
        ded_in_pins = 4'h0;
        glb_clk_sel = 32'h0;
        io_clk_sel  = 64'h0;
        io_pin_in   = 64'h0;
        array_out   = 64'h0;
        array_oe    = 64'h0;
        error_cnt   = 0;
        comparisons = 0;
        cyc         = 0;
        cycles(8);
        rst_b = 1'b1;
        cycles(2);
        t_normal();
        t_program();
        t_reset();
        t_clocks();
        conclude();
    end
endmodule
